// ===== hw/acd_consts.svh
// Constants for the amplifier control and diagnostic serial target
`ifndef ACD_CONSTS_SVH
`define ACD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Bus framing
// ----------------------------------------------------------------------------
`define ACD_ADDR_HI    5'h1A
`define ACD_LAST_BIT   4'h7
`define ACD_ACK_SLOT   4'h8

// ----------------------------------------------------------------------------
// Control byte fields and reset values
// ----------------------------------------------------------------------------
`define ACD_IB1_DIAG   6
`define ACD_IB1_OFS    5
`define ACD_IB1_GAIN   4
`define ACD_IB1_UNMUTE 2
`define ACD_IB1_CLIP   0
`define ACD_IB2_RUN    4
`define ACD_IB2_LINE   3
`define ACD_IB2_HE     1
`define ACD_IB1_RST    8'h00
`define ACD_IB2_RST    8'h00

// ----------------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------------
`define ACD_DB1_THERM  7
`define ACD_DB1_DONE   6
`define ACD_DB2_OFSACT 7

// ----------------------------------------------------------------------------
// Positions in the pin synchroniser vector
// ----------------------------------------------------------------------------
`define ACD_SY_SCL     0
`define ACD_SY_SDA     1
`define ACD_SY_EN      2
`define ACD_SY_T1      3
`define ACD_SY_T2      4
`define ACD_SY_TR      5
`define ACD_SY_STBY    6
`define ACD_SY_HE      7
`define ACD_SY_MUTE    8

`endif

// ===== hw/acd_pkg.sv
// Types shared by the amplifier control and diagnostic serial target
`default_nettype none
package acd_pkg;

  // Per-channel fault flags, packed in status byte order bits 4..0
  typedef struct packed {
    logic perm;
    logic short_load;
    logic open_or_ofs;
    logic short_vs;
    logic short_gnd;
  } acd_ch_diag_t;

  // Decoded amplifier controls
  typedef struct packed {
    logic amp_on;
    logic play;
    logic high_eff;
    logic gain_12db;
    logic clip_10pct;
    logic diag_en;
    logic offset_en;
    logic line_drv;
  } acd_amp_ctl_t;

  // Frame state seen from the system clock
  typedef enum logic [1:0] {
    ACD_IDLE  = 2'b00,
    ACD_START = 2'b01,
    ACD_LIVE  = 2'b10
  } acd_frame_t;

  // System clock domain state
  typedef struct packed {
    logic [8:0]   s1;
    logic [8:0]   s2;
    logic [8:0]   s3;
    acd_frame_t   st;
    logic [7:0]   ib1;
    logic [7:0]   ib2;
    logic [7:0]   snap1;
    logic [7:0]   snap2;
    acd_amp_ctl_t ctl;
    logic         rearm;
    logic         ofs_restart;
  } acd_sys_t;

  // Link state cleared at every frame
  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] bn;
    logic       act;
    logic       rd;
  } acd_link_t;

  // Link state that outlives frames
  typedef struct packed {
    logic [7:0] ib1;
    logic [7:0] ib2;
    logic       t1;
    logic       t2;
    logic       tr;
  } acd_keep_t;

endpackage
`default_nettype wire

// ===== hw/acd_target.sv
// Serial control and diagnostic target of a dual bridge amplifier
//
// Functional notes
// - Bytes are eight bits, MSB first, plus ack
// - Byte sender releases data line during ack
// - Device pulls ack low for address and control
// - Address 11010, two strap bits, then read/write
// - Write carries first then second control byte
// - First byte bits 6,5 enable diagnostics, offset
// - First byte bits 4,2,0 gain, unmute, clip
// - Second byte bit 4 leaves standby
// - Second byte bit 3 selects line-driver thresholds
// - Second byte bit 1 selects high efficiency
// - Strap high enables interface, low disables it
// - Play needs mute pin and unmute bit
// - Standby pin low always switches amplifier off
// - Interface off: pins alone choose mode, play
// - Read returns first then second status byte
// - Status bit 7 thermal, bit 6 cycle done
// - Status bits 4,3,1,0 kind and shorts
// - Status bit 2 open load or offset
// - Second status bit 7 shows offset detection on
// - Start and stop framed by data with clock high
// - Status read rearms the next diagnostic cycle
// - Offset window restarts at read or enable
`default_nettype none
`include "acd_consts.svh"

module acd_target (
  // System clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Serial link, clock is its own domain
  input  wire logic                 scl,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  // Straps and analog comparator levels
  input  wire logic                 if_enable_strap,
  input  wire logic [1:0]           addr_sel,
  input  wire logic                 standby_pin,
  input  wire logic                 standby_pin_he,
  input  wire logic                 mute_pin,
  // Diagnostic engine results
  input  wire logic                 thermal_warn,
  input  wire logic                 diag_done,
  input  wire acd_pkg::acd_ch_diag_t ch1_diag,
  input  wire acd_pkg::acd_ch_diag_t ch2_diag,
  // Amplifier controls and diagnostic strobes
  output acd_pkg::acd_amp_ctl_t     amp_ctl,
  output logic                      diag_rearm,
  output logic                      ofs_restart
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  acd_pkg::acd_sys_t  sq;
  acd_pkg::acd_sys_t  next_sq;
  acd_pkg::acd_link_t lk;
  acd_pkg::acd_link_t next_lk;
  acd_pkg::acd_keep_t lp;
  acd_pkg::acd_keep_t next_lp;
  logic               next_oe;
  logic               frame_rst;
  logic               ack_ok;
  logic [7:0]         tx_byte;
  logic [8:0]         pins;
  logic               start_seen;
  logic               stop_seen;
  logic               en;
  logic [7:0]         db1;
  logic [7:0]         db2;

  // --------------------------------------------------------------------------
  // System domain
  // --------------------------------------------------------------------------

  // Pin levels and link toggles pass two flops before use
  assign pins = {mute_pin, standby_pin_he, standby_pin, lp.tr, lp.t2, lp.t1,
                 if_enable_strap, sda_i, scl};

  // Edges seen between second and third stage only
  assign start_seen = sq.s2[`ACD_SY_SCL] && sq.s3[`ACD_SY_SCL] &&
                      sq.s3[`ACD_SY_SDA] && !sq.s2[`ACD_SY_SDA];
  assign stop_seen  = sq.s2[`ACD_SY_SCL] && sq.s3[`ACD_SY_SCL] &&
                      !sq.s3[`ACD_SY_SDA] && sq.s2[`ACD_SY_SDA];
  assign en = sq.s2[`ACD_SY_EN];

  // Status bytes assembled from the diagnostic engine
  always_comb begin
    db1 = {3'h0, ch1_diag};
    db1[`ACD_DB1_THERM] = thermal_warn;
    db1[`ACD_DB1_DONE] = diag_done;
    db2 = {3'h0, ch2_diag};
    db2[`ACD_DB2_OFSACT] = sq.ctl.offset_en;
  end

  // Link frame state and output enable are held in reset outside a live frame
  assign frame_rst = rst || (sq.st != acd_pkg::ACD_LIVE);

  // Next system state
  always_comb begin
    next_sq = sq;
    if (ce) begin
      next_sq.s1 = pins;
      next_sq.s2 = sq.s1;
      next_sq.s3 = sq.s2;
      next_sq.rearm = 1'b0;
      next_sq.ofs_restart = 1'b0;
      // Frame tracking; release waits for clock low so no edge races reset
      case (sq.st)
        acd_pkg::ACD_IDLE: begin
          if (start_seen) next_sq.st = acd_pkg::ACD_START;
        end
        acd_pkg::ACD_START: begin
          if (!sq.s2[`ACD_SY_SCL]) next_sq.st = acd_pkg::ACD_LIVE;
        end
        acd_pkg::ACD_LIVE: begin
          if (stop_seen) next_sq.st = acd_pkg::ACD_IDLE;
          else if (start_seen) next_sq.st = acd_pkg::ACD_START;
        end
        default: begin
          next_sq.st = acd_pkg::ACD_IDLE;
        end
      endcase
      if (!en) next_sq.st = acd_pkg::ACD_IDLE;
      // Snapshot frozen during a frame so the link reads stable bits
      if (sq.st != acd_pkg::ACD_LIVE) begin
        next_sq.snap1 = db1;
        next_sq.snap2 = db2;
      end
      // Each control byte copied once its eighth bit is captured, before its ack slot
      if (sq.s2[`ACD_SY_T1] != sq.s3[`ACD_SY_T1]) begin
        next_sq.ib1 = lp.ib1;
        if (lp.ib1[`ACD_IB1_OFS] && !sq.ib1[`ACD_IB1_OFS]) next_sq.ofs_restart = 1'b1;
      end
      if (sq.s2[`ACD_SY_T2] != sq.s3[`ACD_SY_T2]) next_sq.ib2 = lp.ib2;
      // Pin low drops the run bit, so only a new command restarts
      if (!sq.s2[`ACD_SY_STBY]) next_sq.ib2[`ACD_IB2_RUN] = 1'b0;
      // Completed status read rearms diagnostics and offset window
      if (sq.s2[`ACD_SY_TR] != sq.s3[`ACD_SY_TR]) begin
        next_sq.rearm = 1'b1;
        next_sq.ofs_restart = 1'b1;
      end
      // Decoded controls
      if (en) begin
        next_sq.ctl.amp_on = sq.s2[`ACD_SY_STBY] && sq.ib2[`ACD_IB2_RUN];
        next_sq.ctl.high_eff = sq.ib2[`ACD_IB2_HE];
        next_sq.ctl.play = sq.s2[`ACD_SY_STBY] && sq.ib2[`ACD_IB2_RUN] &&
                           sq.s2[`ACD_SY_MUTE] && sq.ib1[`ACD_IB1_UNMUTE];
      end else begin
        next_sq.ctl.amp_on = sq.s2[`ACD_SY_STBY];
        next_sq.ctl.high_eff = sq.s2[`ACD_SY_HE];
        next_sq.ctl.play = sq.s2[`ACD_SY_STBY] && sq.s2[`ACD_SY_MUTE];
      end
      next_sq.ctl.gain_12db = en && sq.ib1[`ACD_IB1_GAIN];
      next_sq.ctl.clip_10pct = en && sq.ib1[`ACD_IB1_CLIP];
      next_sq.ctl.diag_en = en && sq.ib1[`ACD_IB1_DIAG];
      next_sq.ctl.offset_en = en && sq.ib1[`ACD_IB1_OFS];
      next_sq.ctl.line_drv = en && sq.ib2[`ACD_IB2_LINE];
    end
  end

  // System state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sq <= '{s1: 9'h000, s2: 9'h000, s3: 9'h000, st: acd_pkg::ACD_IDLE,
              ib1: `ACD_IB1_RST, ib2: `ACD_IB2_RST, snap1: 8'h00, snap2: 8'h00,
              ctl: '0, rearm: 1'b0, ofs_restart: 1'b0};
    end else begin
      sq <= next_sq;
    end
  end

  assign amp_ctl     = sq.ctl;
  assign diag_rearm  = sq.rearm;
  assign ofs_restart = sq.ofs_restart;

  // --------------------------------------------------------------------------
  // Link domain
  // --------------------------------------------------------------------------

  // Ack only the address and the two control bytes of a write
  assign ack_ok  = lk.act && (lk.bn == 2'h0 || (!lk.rd && lk.bn != 2'h3));
  assign tx_byte = (lk.bn == 2'h1) ? sq.snap1 : sq.snap2;

  // Shift, address match and byte capture on rising clock
  always_comb begin
    next_lk = lk;
    next_lp = lp;
    if (lk.cnt != `ACD_ACK_SLOT) begin
      next_lk.sh = {lk.sh[6:0], sda_i};
      next_lk.cnt = lk.cnt + 4'h1;
      if (lk.cnt == `ACD_LAST_BIT) begin
        if (lk.bn == 2'h0) begin
          next_lk.act = (lk.sh[6:2] == `ACD_ADDR_HI) && (lk.sh[1:0] == addr_sel);
          next_lk.rd = sda_i;
        end else if (lk.act && !lk.rd && lk.bn == 2'h1) begin
          next_lp.ib1 = {lk.sh[6:0], sda_i};
          next_lp.t1 = ~lp.t1;
        end else if (lk.act && !lk.rd && lk.bn == 2'h2) begin
          next_lp.ib2 = {lk.sh[6:0], sda_i};
          next_lp.t2 = ~lp.t2;
        end
      end
    end else begin
      next_lk.cnt = 4'h0;
      if (lk.bn != 2'h3) next_lk.bn = lk.bn + 2'h1;
      // Host not acknowledging ends our transmission
      if (lk.act && lk.rd && lk.bn != 2'h0 && sda_i) next_lk.act = 1'b0;
      if (lk.act && lk.rd && lk.bn == 2'h2) next_lp.tr = ~lp.tr;
    end
  end

  // Data driven on falling clock so it changes only while low
  always_comb begin
    next_oe = 1'b0;
    if (lk.cnt == `ACD_ACK_SLOT) begin
      next_oe = ack_ok;
    end else if (lk.act && lk.rd && lk.bn != 2'h0 && lk.bn != 2'h3) begin
      next_oe = !tx_byte[3'(`ACD_LAST_BIT - lk.cnt)];
    end
  end

  // Frame state, cleared by every start and between frames
  always_ff @(posedge scl or posedge frame_rst) begin
    if (frame_rst) lk <= '0;
    else lk <= next_lk;
  end

  // Control bytes and toggles live across frames
  always_ff @(posedge scl or posedge rst) begin
    if (rst) lp <= '{ib1: `ACD_IB1_RST, ib2: `ACD_IB2_RST, t1: 1'b0, t2: 1'b0, tr: 1'b0};
    else lp <= next_lp;
  end

  // Output enable register
  always_ff @(negedge scl or posedge frame_rst) begin
    if (frame_rst) sda_oe <= 1'b0;
    else sda_oe <= next_oe;
  end

  assign sda_o = 1'b0;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_ack_low_held: assert property (@(posedge scl) disable iff (frame_rst)
    (lk.cnt == `ACD_ACK_SLOT && ack_ok) |-> sda_oe)
    else $error("ack not driven low");
  a_read_ack_free: assert property (@(posedge scl) disable iff (frame_rst)
    (lk.cnt == `ACD_ACK_SLOT && lk.rd && lk.bn != 2'h0) |-> !sda_oe)
    else $error("line held in host ack slot");
  a_addr_mismatch: assert property (@(posedge scl) disable iff (frame_rst)
    (lk.cnt == `ACD_LAST_BIT && lk.bn == 2'h0 && lk.sh[6:2] != `ACD_ADDR_HI) |=> !lk.act)
    else $error("foreign address accepted");
  a_strap_ignore: assert property (@(posedge clk) disable iff (rst)
    (ce && !en) |=> frame_rst [*2])
    else $error("frame live while disabled");
  a_standby_off: assert property (@(posedge clk) disable iff (rst)
    (ce && !sq.s2[`ACD_SY_STBY]) |=> (!amp_ctl.amp_on && !amp_ctl.play))
    else $error("amplifier on with standby low");
  a_play_gate: assert property (@(posedge clk) disable iff (rst)
    (ce && en && !sq.ib1[`ACD_IB1_UNMUTE]) |=> !amp_ctl.play)
    else $error("play without unmute bit");
  a_pin_mode: assert property (@(posedge clk) disable iff (rst)
    (ce && !en) |=> (amp_ctl.high_eff == $past(sq.s2[`ACD_SY_HE]) && !amp_ctl.gain_12db))
    else $error("pin mode not followed");
  a_byte_copy: assert property (@(posedge clk) disable iff (rst)
    (ce && sq.s2[`ACD_SY_T1] != sq.s3[`ACD_SY_T1]) |=> sq.ib1 == $past(lp.ib1))
    else $error("first control byte not copied");
  a_read_rearm: assert property (@(posedge clk) disable iff (rst)
    (ce && sq.s2[`ACD_SY_TR] != sq.s3[`ACD_SY_TR]) |=> (diag_rearm && ofs_restart))
    else $error("read did not rearm");
  a_offset_flag: assert property (@(posedge clk) disable iff (rst)
    (ce && sq.st != acd_pkg::ACD_LIVE) |=> sq.snap2[`ACD_DB2_OFSACT] == $past(amp_ctl.offset_en))
    else $error("offset flag wrong");

endmodule // acd_target
`default_nettype wire

// ===== tb/acd_host.sv
// Host controller model that drives the serial link of the target
`default_nettype none
module acd_host (
  // Link lines, data resolved outside with a pull-up
  output var logic scl,
  output var logic sda_pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock stands high and data is released between frames
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Start: data falls with clock high, clock held high long enough
  task automatic start_cond();
    sda_pull = 1'b1;
    #24;
    scl = 1'b0;
  endtask

  // One bit: data moves only in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #12;
    sda_pull = ~b;
    #12;
    scl = 1'b1;
    #12;
    r = sda;
    #12;
    scl = 1'b0;
  endtask

  // Byte then ack slot; sender releases, receiver pulls low
  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack_seen);
  endtask

  // Stop: data rises while clock high, then bus left idle
  task automatic stop_cond();
    #12;
    sda_pull = 1'b1;
    #12;
    scl = 1'b1;
    #12;
    sda_pull = 1'b0;
    #24;
  endtask
endmodule // acd_host
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the amplifier control and diagnostic target
`default_nettype none
`include "acd_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  clk, rst, ce, scl, sda_pull, sda, sda_o, sda_oe;
  logic                  strap, stby, stby_he, mute, therm, done, rearm, ofs;
  logic [1:0]            asel;
  logic [2:0]            acks;
  logic [7:0]            cur1, cur2;
  acd_pkg::acd_ch_diag_t ch1, ch2;
  acd_pkg::acd_amp_ctl_t ctl;
  int                    mismatches = 0, comparisons = 0, n_rearm = 0, n_ofs = 0;

  // Open-drain wire with pull-up
  assign sda = ~(sda_pull | sda_oe);

  acd_target uut (.clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .if_enable_strap(strap), .addr_sel(asel), .standby_pin(stby), .standby_pin_he(stby_he), .mute_pin(mute),
    .thermal_warn(therm), .diag_done(done), .ch1_diag(ch1), .ch2_diag(ch2), .amp_ctl(ctl),
    .diag_rearm(rearm), .ofs_restart(ofs));
  acd_host host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulse counters, so one-cycle strobes are never missed
  always @(posedge clk) begin
    if (rearm === 1'b1) n_rearm++;
    if (ofs === 1'b1) n_ofs++;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Expected controls from pins and stored bytes
  function automatic logic [7:0] exp_ctl(input logic [7:0] b1, input logic [7:0] b2);
    logic on;
    on = stby & b2[4];
    if (!strap) return {stby, stby & mute, stby_he, 5'h00};
    return {on, on & mute & b1[2], b2[1], b1[4], b1[0], b1[6], b1[5], b2[3]};
  endfunction

  // Bounded wait for the controls; syncs add a few cycles of lag
  task automatic wait_ctl(input logic [7:0] exp);
    int k;
    k = 0;
    while (ctl !== exp && k < 60) begin
      @(posedge clk);
      k++;
    end
    check("amp_ctl", ctl, exp);
    if (k == 60 && ctl !== exp) results();
  endtask

  // Write frame carrying n control bytes; ack bits collected in acks
  task automatic wr(input logic [7:0] a, input logic [7:0] b1, input logic [7:0] b2, input int n);
    logic [7:0] q;
    acks = 3'b000;
    host.start_cond();
    host.byte_io(a, 1'b1, q, acks[2]);
    if (n > 0) host.byte_io(b1, 1'b1, q, acks[1]);
    if (n > 1) host.byte_io(b2, 1'b1, q, acks[0]);
    host.stop_cond();
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_write();
    logic [7:0] t1 [3] = '{8'h75, 8'h8A, 8'h24};
    logic [7:0] t2 [3] = '{8'h1A, 8'hE5, 8'h10};
    int o0;
    o0 = n_ofs;
    for (int i = 0; i < 3; i++) begin
      wr({`ACD_ADDR_HI, asel, 1'b0}, t1[i], t2[i], 2);
      check("write acks", {5'h00, acks}, 8'h00);
      wait_ctl(exp_ctl(t1[i], t2[i]));
    end
    cur1 = 8'h24;
    cur2 = 8'h10;
    check("offset restarts", 8'(n_ofs - o0), 8'h02);
    @(posedge clk);
    #1 mute = 1'b0;
    wait_ctl(exp_ctl(cur1, cur2));
    #1 mute = 1'b1;
    wait_ctl(exp_ctl(cur1, cur2));
    $display("done: write table");
  endtask

  task automatic t_badaddr();
    wr({`ACD_ADDR_HI, ~asel, 1'b0}, 8'h00, 8'h00, 2);
    check("foreign addr ack", {7'h00, acks[2]}, 8'h01);
    repeat (20) @(posedge clk);
    check("amp_ctl kept", ctl, exp_ctl(cur1, cur2));
    $display("done: foreign address");
  endtask

  task automatic t_partial();
    wr({`ACD_ADDR_HI, asel, 1'b0}, 8'h71, 8'h00, 1);
    cur1 = 8'h71;
    wait_ctl(exp_ctl(cur1, cur2));
    $display("done: partial write");
  endtask

  task automatic t_read();
    logic [7:0] q, d1, d2;
    logic       a;
    int         r0, o0, k;
    r0 = n_rearm;
    o0 = n_ofs;
    host.start_cond();
    host.byte_io({`ACD_ADDR_HI, asel, 1'b1}, 1'b1, q, a);
    check("read addr ack", {7'h00, a}, 8'h00);
    check("sda_o", {7'h00, sda_o}, 8'h00);
    host.byte_io(8'hFF, 1'b0, d1, a);
    host.byte_io(8'hFF, 1'b1, d2, a);
    host.stop_cond();
    check("status one", d1 & 8'hDF, 8'hD5);
    check("status two", d2 & 8'h9F, 8'h8A);
    k = 0;
    while (n_rearm == r0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    check("rearm pulses", 8'(n_rearm - r0), 8'h01);
    check("offset window", 8'(n_ofs - o0), 8'h01);
    $display("done: status read");
  endtask

  task automatic t_standby();
    logic [7:0] e;
    e = exp_ctl(cur1, cur2);
    // Clock enable low must freeze the decoded controls
    @(posedge clk);
    #1 ce = 1'b0;
    stby = 1'b0;
    repeat (10) @(posedge clk);
    check("frozen amp_ctl", ctl, e);
    #1 ce = 1'b1;
    cur2[4] = 1'b0;
    wait_ctl(exp_ctl(cur1, cur2));
    #1 stby = 1'b1;
    repeat (20) @(posedge clk);
    check("stays off", ctl, exp_ctl(cur1, cur2));
    wr({`ACD_ADDR_HI, asel, 1'b0}, 8'h04, 8'h12, 2);
    cur1 = 8'h04;
    cur2 = 8'h12;
    wait_ctl(exp_ctl(cur1, cur2));
    $display("done: standby pin");
  endtask

  task automatic t_disabled();
    @(posedge clk);
    #1 strap = 1'b0;
    stby_he = 1'b1;
    wait_ctl(exp_ctl(cur1, cur2));
    #1 mute = 1'b0;
    wait_ctl(exp_ctl(cur1, cur2));
    wr({`ACD_ADDR_HI, asel, 1'b0}, 8'h00, 8'h00, 2);
    check("disabled ack", {7'h00, acks[2]}, 8'h01);
    @(posedge clk);
    #1 strap = 1'b1;
    mute = 1'b1;
    wait_ctl(exp_ctl(cur1, cur2));
    $display("done: interface disabled");
  endtask

  // Main sequence
  initial begin
    rst     = 1'b1;
    ce      = 1'b1;
    strap   = 1'b1;
    stby    = 1'b1;
    stby_he = 1'b0;
    mute    = 1'b1;
    therm   = 1'b1;
    done    = 1'b1;
    asel    = 2'b10;
    ch1     = acd_pkg::acd_ch_diag_t'(5'h15);
    ch2     = acd_pkg::acd_ch_diag_t'(5'h0A);
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    t_write();
    t_badaddr();
    t_partial();
    t_read();
    t_standby();
    t_disabled();
    results();
  end
endmodule // tb
`default_nettype wire
